// ==== dsg_fabric.sv ====
// Peripheral fabric model issuing unit accesses
`timescale 1ns/1ps
`default_nettype none
module dsg_fabric (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	output dsg_pkg::dsg_units_t acc_req
);
	import dsg_pkg::*;
	int seed = 32'h2fb3;
	logic [31:0] rnd;
	// ==========================================================
	// Random accesses, blind to the enables like real software
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_req <= 9'h000;
		end else begin
			rnd = $random(seed);
			acc_req <= go ? rnd[8:0] : 9'h000;
		end
	end
endmodule // dsg_fabric
`default_nettype wire

// ==== dsg_gate_properties.sv ====
// Checker for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_gate_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic pwr_sleep,
	input wire logic pwr_deep,
	input wire dsg_pkg::dsg_units_t acc_req,
	input wire dsg_pkg::dsg_units_t acc_fault,
	input wire dsg_pkg::dsg_units_t unit_clk_en,
	input wire dsg_pkg::dsg_units_t unit_gclk,
	input wire logic irq
);
	import dsg_pkg::*;
	logic take;
	logic [1:0] pw_q;
	logic [2:0] age_q;
	assign take = hsel && hready && htrans[1] && ce;
	// ==========================================================
	// Age of the last cause that may move the enables
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pw_q <= 2'h0;
			age_q <= 3'h7;
		end else begin
			pw_q <= {pwr_sleep, pwr_deep};
			if ((take && hwrite) || {pwr_sleep, pwr_deep} != pw_q)
				age_q <= 3'h0;
			else if (age_q != 3'h7)
				age_q <= age_q + 3'h1;
		end
	end
	// ==========================================================
	// Properties
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_fault_on_off: assert property (ce |=> acc_fault == $past(acc_req & ~unit_clk_en))
		else $error("fault pulse does not match access to an unclocked unit");
	a_reset_all_off: assert property ($rose(hresetn) |-> unit_clk_en == 9'h000 && irq == 1'b0)
		else $error("units or interrupt active right after reset");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_no_wait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_enable_has_cause: assert property (!$stable(unit_clk_en) |-> age_q <= 3'h3)
		else $error("enables moved without write or power change");
	a_rdata_holds: assert property (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
		else $error("read data changed outside a read");
	a_gclk_follows: assert property (@(negedge hclk) $stable(unit_clk_en) |-> unit_gclk == unit_clk_en)
		else $error("gated clock disagrees with enable");
	c_fault: cover property (acc_fault != 9'h000);
	c_read: cover property (take && !hwrite);
	c_irq: cover property ($rose(irq));
endmodule // dsg_gate_properties
bind dsg_top dsg_gate_properties dsg_gate_properties_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.pwr_sleep(pwr_sleep), .pwr_deep(pwr_deep), .acc_req(acc_req), .acc_fault(acc_fault),
	.unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk), .irq(irq));
`default_nettype wire

// ==== dsg_pkg.sv ====
// Constants, types and helpers for the deep-sleep unit clock gating block
package dsg_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [11:0] DSG_RUN_OFS = 12'h104;
	localparam logic [11:0] DSG_SLEEP_OFS = 12'h114;
	localparam logic [11:0] DSG_DEEP_OFS = 12'h124;
	localparam logic [11:0] DSG_CTRL_OFS = 12'h160;
	localparam logic [11:0] DSG_ISTS_OFS = 12'h170;
	localparam logic [11:0] DSG_IMSK_OFS = 12'h174;
	localparam logic [11:0] DSG_ACT_OFS = 12'h178;
	localparam logic [11:0] DSG_MODE_OFS = 12'h17c;

	// ==========================================================
	// Field layout of the gating, status and control words
	localparam int DSG_B_COMPARATOR_ONE_GATE = 25;
	localparam int DSG_B_COMPARATOR_ZERO_GATE = 24;
	localparam int DSG_B_TMR2 = 18;
	localparam int DSG_B_TMR1 = 17;
	localparam int DSG_B_TMR0 = 16;
	localparam int DSG_B_TWI = 12;
	localparam int DSG_B_SSU = 4;
	localparam int DSG_B_ASY1 = 1;
	localparam int DSG_B_ASY0 = 0;
	localparam int DSG_B_MODE_CHG = 31;
	localparam int DSG_B_AUTO = 0;
	localparam logic [31:0] DSG_GATE_WMASK = 32'h0307_1013;
	localparam logic [31:0] DSG_ISTS_WMASK = 32'h8307_1013;
	localparam logic [31:0] DSG_GATE_RST = 32'h0000_0000;
	localparam logic [31:0] DSG_CTRL_RST = 32'h0000_0000;
	localparam int DSG_UNITS = 9;

	// ==========================================================
	// Types
	typedef struct packed {
		logic comparator_one_gate;
		logic comparator_zero_gate;
		logic gp_timer_two_gate;
		logic gp_timer_one_gate;
		logic gp_timer_zero_gate;
		logic two_wire_unit_gate;
		logic sync_serial_unit_gate;
		logic async_serial_one_gate;
		logic async_serial_zero_gate;
	} dsg_units_t;

	typedef enum logic [2:0] {
		DSG_MODE_RUN = 3'h1,
		DSG_MODE_SLEEP = 3'h2,
		DSG_MODE_DEEP = 3'h4
	} dsg_mode_t;

	typedef enum logic [2:0] {
		DSG_BUS_IDLE = 3'h1,
		DSG_BUS_RDWAIT = 3'h2,
		DSG_BUS_RDDONE = 3'h4
	} dsg_bus_t;

	// ==========================================================
	// Word <-> unit vector
	function automatic dsg_units_t dsg_units_of(input logic [31:0] w);
		dsg_units_t u;
		u.comparator_one_gate = w[DSG_B_COMPARATOR_ONE_GATE];
		u.comparator_zero_gate = w[DSG_B_COMPARATOR_ZERO_GATE];
		u.gp_timer_two_gate = w[DSG_B_TMR2];
		u.gp_timer_one_gate = w[DSG_B_TMR1];
		u.gp_timer_zero_gate = w[DSG_B_TMR0];
		u.two_wire_unit_gate = w[DSG_B_TWI];
		u.sync_serial_unit_gate = w[DSG_B_SSU];
		u.async_serial_one_gate = w[DSG_B_ASY1];
		u.async_serial_zero_gate = w[DSG_B_ASY0];
		return u;
	endfunction

	function automatic logic [31:0] dsg_word_of(input dsg_units_t u);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[DSG_B_COMPARATOR_ONE_GATE] = u.comparator_one_gate;
		w[DSG_B_COMPARATOR_ZERO_GATE] = u.comparator_zero_gate;
		w[DSG_B_TMR2] = u.gp_timer_two_gate;
		w[DSG_B_TMR1] = u.gp_timer_one_gate;
		w[DSG_B_TMR0] = u.gp_timer_zero_gate;
		w[DSG_B_TWI] = u.two_wire_unit_gate;
		w[DSG_B_SSU] = u.sync_serial_unit_gate;
		w[DSG_B_ASY1] = u.async_serial_one_gate;
		w[DSG_B_ASY0] = u.async_serial_zero_gate;
		return w;
	endfunction

endpackage

// ==== dsg_top.sv ====
// Deep-sleep unit clock gating block with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dsg_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic pwr_sleep,
	input wire logic pwr_deep,
	input wire dsg_pkg::dsg_units_t acc_req,
	output dsg_pkg::dsg_units_t acc_fault,
	output dsg_pkg::dsg_units_t unit_clk_en,
	output dsg_pkg::dsg_units_t unit_gclk,
	output logic irq
);

	import dsg_pkg::*;

	// ==========================================================
	// Declarations
	dsg_bus_t bus_q;
	dsg_bus_t bus_d;
	dsg_mode_t mode_q;
	dsg_mode_t mode_d;
	logic addr_ok;
	logic wr_pend_q;
	logic [11:0] wr_addr_q;
	logic [11:0] rd_addr_q;
	logic [31:0] rd_word;
	logic [31:0] hrdata_q;
	logic [31:0] run_q;
	logic [31:0] sleep_q;
	logic [31:0] deep_q;
	logic [31:0] ctrl_q;
	logic [31:0] ists_q;
	logic [31:0] imsk_q;
	logic [31:0] sel_word;
	logic [31:0] act_word;
	logic [31:0] fault_word;
	logic [31:0] ists_set;
	logic [31:0] ists_clr;
	logic mode_chg;
	logic auto_en;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_ctrl;
	logic wr_ists;
	logic wr_imsk;
	logic wr_live;
	logic irq_q;
	logic [DSG_UNITS-1:0] sel_vec;
	logic [DSG_UNITS-1:0] req_vec;
	logic [DSG_UNITS-1:0] en_vec;
	logic [DSG_UNITS-1:0] gclk_vec;
	logic [DSG_UNITS-1:0] fault_vec;

	// ==========================================================
	// Write decode, shared by all register processes
	// Every operand is an argument, so each assign re-evaluates when it moves
	function automatic logic is_wr(
		input logic live,
		input logic [11:0] addr,
		input logic [11:0] ofs
	);
		return live && (addr == ofs);
	endfunction

	assign wr_live = wr_pend_q && ce;
	assign wr_run = is_wr(wr_live, wr_addr_q, DSG_RUN_OFS);
	assign wr_sleep = is_wr(wr_live, wr_addr_q, DSG_SLEEP_OFS);
	assign wr_deep = is_wr(wr_live, wr_addr_q, DSG_DEEP_OFS);
	assign wr_ctrl = is_wr(wr_live, wr_addr_q, DSG_CTRL_OFS);
	assign wr_ists = is_wr(wr_live, wr_addr_q, DSG_ISTS_OFS);
	assign wr_imsk = is_wr(wr_live, wr_addr_q, DSG_IMSK_OFS);

	// ==========================================================
	// AHB-Lite address phase
	// Only whole-word single transfers are expected; hsize is not checked
	assign addr_ok = hsel && hready && htrans[1];
	assign hresp = 1'b0;

	// Read stall keeps hrdata registered and sees a write of the prior beat
	assign hreadyout = ce && (bus_q != DSG_BUS_RDWAIT);
	assign hrdata = hrdata_q;

	always_comb begin
		bus_d = bus_q;
		case (bus_q)
			DSG_BUS_IDLE: begin
				if (addr_ok && !hwrite) begin
					bus_d = DSG_BUS_RDWAIT;
				end
			end
			DSG_BUS_RDWAIT: begin
				bus_d = DSG_BUS_RDDONE;
			end
			DSG_BUS_RDDONE: begin
				if (addr_ok && !hwrite) begin
					bus_d = DSG_BUS_RDWAIT;
				end else begin
					bus_d = DSG_BUS_IDLE;
				end
			end
			default: begin
				bus_d = DSG_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= DSG_BUS_IDLE;
		end else if (ce) begin
			bus_q <= bus_d;
		end
	end

	// Read address held for the wait cycle, when the mux is sampled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_addr_q <= 12'h000;
		end else if (ce && addr_ok && !hwrite) begin
			rd_addr_q <= haddr[11:0];
		end
	end

	// Write stays pending while ce is low, as hreadyout holds the master
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else if (ce) begin
			wr_pend_q <= addr_ok && hwrite;
			if (addr_ok && hwrite) begin
				wr_addr_q <= haddr[11:0];
			end
		end
	end

	// ==========================================================
	// Gating registers
	// Reserved bits are masked on write, so they can only read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q <= DSG_GATE_RST;
		end else if (wr_run) begin
			run_q <= hwdata & DSG_GATE_WMASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_q <= DSG_GATE_RST;
		end else if (wr_sleep) begin
			sleep_q <= hwdata & DSG_GATE_WMASK;
		end
	end

	// Nothing is enabled until software sets it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deep_q <= DSG_GATE_RST;
		end else if (wr_deep) begin
			deep_q <= hwdata & DSG_GATE_WMASK;
		end
	end

	// Only the auto gating bit is kept; the rest reads as zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= DSG_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= {31'h0000_0000, hwdata[DSG_B_AUTO]};
		end
	end

	assign auto_en = ctrl_q[DSG_B_AUTO];

	// ==========================================================
	// Power state and register selection
	always_comb begin
		mode_d = DSG_MODE_RUN;
		if (auto_en && pwr_deep) begin
			mode_d = DSG_MODE_DEEP;
		end else if (auto_en && pwr_sleep) begin
			mode_d = DSG_MODE_SLEEP;
		end
	end

	// Registered, so a power change moves the mode one edge later and the enables two edges later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= DSG_MODE_RUN;
		end else if (ce) begin
			mode_q <= mode_d;
		end
	end

	assign mode_chg = (mode_q != mode_d);

	// Selected word feeds the gates; a register switch lands on the next edge
	always_comb begin
		case (mode_q)
			DSG_MODE_RUN: begin
				sel_word = run_q;
			end
			DSG_MODE_SLEEP: begin
				sel_word = sleep_q;
			end
			DSG_MODE_DEEP: begin
				sel_word = deep_q;
			end
			default: begin
				sel_word = run_q;
			end
		endcase
	end

	assign sel_vec = dsg_units_of(sel_word);
	assign req_vec = acc_req;

	// ==========================================================
	// Per-unit gates
	// Faults are judged against the applied enable, not the written word
	genvar gi;
	generate
		for (gi = 0; gi < DSG_UNITS; gi++) begin : g_unit
			dsg_unit_gate u_gate (
				.hclk(hclk),
				.hresetn(hresetn),
				.ce(ce),
				.enable(sel_vec[gi]),
				.acc_req(req_vec[gi]),
				.clk_en_q(en_vec[gi]),
				.gclk(gclk_vec[gi]),
				.fault_q(fault_vec[gi])
			);
		end
	endgenerate

	assign unit_clk_en = en_vec;
	assign unit_gclk = gclk_vec;
	assign acc_fault = fault_vec;
	assign act_word = dsg_word_of(en_vec);
	assign fault_word = dsg_word_of(fault_vec);

	// ==========================================================
	// Interrupt status and mask
	// Set wins over a write-one clear in the same cycle
	always_comb begin
		ists_set = fault_word;
		ists_set[DSG_B_MODE_CHG] = ce & mode_chg;
		ists_clr = 32'h0000_0000;
		if (wr_ists) begin
			ists_clr = hwdata & DSG_ISTS_WMASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ists_q <= 32'h0000_0000;
		end else if (ce) begin
			ists_q <= (ists_q & ~ists_clr) | (ists_set & DSG_ISTS_WMASK);
		end
	end

	// Mask shares the status layout, including the mode change bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			imsk_q <= 32'h0000_0000;
		end else if (wr_imsk) begin
			imsk_q <= hwdata & DSG_ISTS_WMASK;
		end
	end

	// Registered level; lags the status by one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= |(ists_q & imsk_q);
		end
	end

	assign irq = irq_q;

	// ==========================================================
	// Read mux; unmapped offsets read as zero
	always_comb begin
		case (rd_addr_q)
			DSG_RUN_OFS: begin
				rd_word = run_q;
			end
			DSG_SLEEP_OFS: begin
				rd_word = sleep_q;
			end
			DSG_DEEP_OFS: begin
				rd_word = deep_q;
			end
			DSG_CTRL_OFS: begin
				rd_word = ctrl_q;
			end
			DSG_ISTS_OFS: begin
				rd_word = ists_q;
			end
			DSG_IMSK_OFS: begin
				rd_word = imsk_q;
			end
			DSG_ACT_OFS: begin
				rd_word = act_word;
			end
			DSG_MODE_OFS: begin
				rd_word = {29'h0000_0000, mode_q};
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Captured in the wait cycle so hrdata leaves straight from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ce && bus_q == DSG_BUS_RDWAIT) begin
			hrdata_q <= rd_word;
		end
	end

endmodule // dsg_top

`default_nettype wire

// ==== dsg_unit_gate.sv ====
// Clock gate and access checker for one peripheral unit
`timescale 1ns/1ps
`default_nettype none

module dsg_unit_gate (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic enable,
	input wire logic acc_req,
	output logic clk_en_q,
	output logic gclk,
	output logic fault_q
);

	logic latch_en;

	// ==========================================================
	// Registered enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_en_q <= 1'b0;
		end else if (ce) begin
			clk_en_q <= enable;
		end
	end

	// ==========================================================
	// Glitch-free gate: latch open while the clock is low
	always_latch begin
		if (!hclk) begin
			latch_en = clk_en_q & ce;
		end
	end

	assign gclk = hclk & latch_en;

	// ==========================================================
	// Fault answer, one cycle after the access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault_q <= 1'b0;
		end else if (ce) begin
			fault_q <= acc_req & ~clk_en_q;
		end
	end

endmodule // dsg_unit_gate

`default_nettype wire

// ==== tb_deep_sleep_clock_gating.sv ====
// Testbench for the deep-sleep clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_deep_sleep_clock_gating;
	import dsg_pkg::*;
	logic hclk, hresetn, hsel, hwrite, pwr_sleep, pwr_deep, go, trk, hreadyout, hresp, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, r, ex;
	dsg_units_t acc_req, acc_fault, unit_clk_en, unit_gclk, seen;
	logic [31:0] g [3];
	logic [11:0] ofs [7] = '{12'h104, 12'h114, 12'h124, 12'h160, 12'h174, 12'h178, 12'h17c};
	int err_total, check_count, seed;
	dsg_top dsg_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .pwr_sleep(pwr_sleep), .pwr_deep(pwr_deep), .acc_req(acc_req), .acc_fault(acc_fault),
		.unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk), .irq(irq));
	dsg_fabric dsg_fabric_inst (.hclk(hclk), .hresetn(hresetn), .go(go), .acc_req(acc_req));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] wd(input dsg_units_t u);
		logic [31:0] w;
		w = 32'h0;
		{w[25], w[24], w[18:16], w[12], w[4], w[1:0]} = u;
		return w;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
		logic ok;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(negedge hclk) ok = hreadyout;
			@(posedge hclk);
		end while (ok !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge hclk) ok = hreadyout;
			rd = hrdata;
			@(posedge hclk);
		end while (ok !== 1'b1);
	endtask
	task automatic final_report;
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge hclk) if (trk) seen <= seen | acc_req;
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial begin
		#100000;
		err_total++;
		final_report;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, pwr_sleep, pwr_deep, go, trk} = 7'h00;
		{htrans, haddr, hwdata, seen} = '0;
		seed = 32'h2fb3;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		hsel <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, ofs[i], 32'h0, r);
			chk(r, (i == 6) ? 32'h1 : 32'h0);
		end
		bus(1'b0, 12'h200, 32'h0, r);
		chk(r, 32'h0);
		for (int k = 0; k < 9; k++) begin
			ex = $random(seed);
			bus(1'b1, ofs[k % 3], ex, r);
			g[k % 3] = ex & wd(9'h1ff);
			bus(1'b0, ofs[k % 3], 32'h0, r);
			chk(r, g[k % 3]);
		end
		for (int a = 0; a < 2; a++) begin
			bus(1'b1, ofs[3], a, r);
			for (int m = 0; m < 3; m++) begin
				pwr_sleep <= (m == 1);
				pwr_deep <= (m == 2);
				repeat (4) @(posedge hclk);
				chk(wd(unit_clk_en), g[a ? m : 0]);
				bus(1'b0, ofs[5], 32'h0, r);
				chk(r, g[a ? m : 0]);
				bus(1'b0, ofs[6], 32'h0, r);
				chk(r, a ? (32'h1 << m) : 32'h1);
			end
		end
		// Status cleared only after the last mode change
		bus(1'b1, ofs[4], 32'hffffffff, r);
		bus(1'b1, 12'h170, 32'hffffffff, r);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		trk <= 1'b1;
		go <= 1'b1;
		repeat (40) @(posedge hclk);
		go <= 1'b0;
		repeat (2) @(posedge hclk);
		trk <= 1'b0;
		repeat (4) @(posedge hclk);
		ex = wd(seen) & ~g[2];
		bus(1'b0, 12'h170, 32'h0, r);
		chk(r, ex);
		chk({31'h0, irq}, {31'h0, |ex});
		bus(1'b1, ofs[4], 32'h0, r);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, ofs[4], 32'hffffffff, r);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, {31'h0, |ex});
		bus(1'b1, 12'h170, 32'hffffffff, r);
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b0, 12'h170, 32'h0, r);
		chk(r, 32'h0);
		// Second reset in mid-run: everything written so far must be gone
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(wd(unit_clk_en), 32'h0);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, ofs[i], 32'h0, r);
			chk(r, (i == 6) ? 32'h1 : 32'h0);
		end
		bus(1'b0, 12'h170, 32'h0, r);
		chk(r, 32'h0);
		final_report;
	end
endmodule // tb_deep_sleep_clock_gating
`default_nettype wire
